// File: rtl/opcode_decode_and_flag_logic.v
// Opcode decoder and condition-flag unit with an APB register port.
// Assumes the datapath (or software) supplies the destination result,
// source, raw carry/overflow and operand-mode qualifiers before execute.
//
// What this block does
// - Case 1: N=MSB, Z=zero, C=0, V=truncated in expanded mode.
// - Case 2: N, Z, carry and overflow.
// - Cases 3,4: N, Z, C=0, V=overflow; case 4 clears V on a narrow magnitude.
// - Case 5: V only on type change overflow.
// - Case 6: flags from source, signed sign.
// - Case 7: N, Z from returned word.
// - Cases 8,9: load whole status word.
// - Case 10: copy bits 18-21 on accept.
// - Status word as source/destination overrides.
// - Size from opcode, two-byte forms forced to word.
// - Overflow in cases 2-5 raises exception; result arrives truncated.
// - Decode move ops and move address.
// - Decode complemented and negated moves.
// - Decode swap and compare-and-swap.
// - Decode two-byte ops, flags unchanged.
// - Decode field extract and insert.
// - Decode divide and modulo.
// - Decode arithmetic shifts.
// - Decode BCD add/subtract, read extend.
// - Extend set/clear; pack, unpack unchanged.
// - Decode AND, XOR, OR forms.
// - Decode compare and test.
`timescale 1ns/1ps
`include "opdec_defs.vh"

module opcode_decode_and_flag_logic (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg [31:0] processor_status_word,
	output reg illegal_opcode,
	output reg integer_overflow
);

	// Decode result in the decode-status layout: case, size, count, illegal, extend use
	function [11:0] decode;
		input [15:0] opc;
		input two_byte;
		reg [3:0] fc;
		reg [2:0] cnt;
		reg [1:0] sz;
		reg ill;
		reg rx;
		reg [7:0] op;
		reg [11:0] res;
		begin
			op = opc[7:0];
			fc = `FC_NONE;
			ill = 1'b0;
			rx = 1'b0;
			// Three-address forms sit in the top quarter of the opcode map
			cnt = (op[7:6] == 2'b11) ? 3'd3 : 3'd2;
			// Size from the low opcode bits
			if (op[1:0] == 2'b11)
				sz = `SIZE_BYTE;
			else if (op[1:0] == 2'b10)
				sz = `SIZE_HALF;
			else
				sz = `SIZE_WORD;
			// Only the prefix byte opens a two-byte opcode; any other is unassigned
			if (two_byte) begin
				sz = `SIZE_WORD;
				cnt = 3'd0;
				if (opc[15:8] != `PREFIX_BYTE)
					ill = 1'b1;
				else if (op == 8'h09 || op == 8'h19 || op == 8'h35 || op == 8'h1F)
					fc = `FC_NONE;
				else
					ill = 1'b1;
			end else begin
				case (op)
					8'h87, 8'h86, 8'h84, 8'h8B, 8'h8A, 8'h88: fc = 4'd1;
					8'h04: begin
						fc = 4'd1;
						sz = `SIZE_WORD;
					end
					8'h8F, 8'h8E, 8'h8C: fc = 4'd2;
					8'h1F, 8'h1E, 8'h1C: fc = 4'd1;
					8'h09: begin
						fc = 4'd2;
						sz = `SIZE_WORD;
						cnt = 3'd3;
					end
					8'hCF, 8'hCE, 8'hCC, 8'hCB, 8'hCA, 8'hC8: begin
						fc = 4'd1;
						cnt = 3'd4;
					end
					8'hAF, 8'hAE, 8'hAC, 8'hA7, 8'hA6, 8'hA4: fc = 4'd3;
					8'hEF, 8'hEE, 8'hEC, 8'hE7, 8'hE6, 8'hE4: fc = 4'd4;
					8'hC0: begin
						fc = 4'd5;
						sz = `SIZE_WORD;
					end
					8'hC7, 8'hC6, 8'hC4: fc = 4'd3;
					8'hA3, 8'hE3, 8'h9B, 8'hDB: begin
						fc = 4'd7;
						rx = 1'b1;
					end
					8'h0B: begin
						fc = `FC_EXT_CLR;
						cnt = 3'd0;
					end
					8'h0A: begin
						fc = `FC_EXT_SET;
						cnt = 3'd0;
					end
					8'h0E, 8'h0F: fc = `FC_NONE;
					8'hBB, 8'hBA, 8'hB8, 8'hB7, 8'hB6, 8'hB4, 8'hB3, 8'hB2, 8'hB0: fc = 4'd1;
					8'hFB, 8'hFA, 8'hF8, 8'hF7, 8'hF6, 8'hF4, 8'hF3, 8'hF2, 8'hF0: fc = 4'd1;
					8'h3F, 8'h3E, 8'h3C: fc = 4'd2;
					8'h2B, 8'h2A, 8'h28: begin
						fc = 4'd6;
						cnt = 3'd1;
					end
					8'h9F, 8'h9E, 8'h9C, 8'hDF, 8'hDE, 8'hDC: fc = 4'd2;
					8'hBF, 8'hBE, 8'hBC, 8'hFF, 8'hFE, 8'hFC: fc = 4'd2;
					8'h93, 8'h92, 8'h90, 8'h97, 8'h96, 8'h94: begin
						fc = 4'd2;
						cnt = 3'd1;
					end
					8'h83, 8'h82, 8'h80: begin
						fc = 4'd2;
						cnt = 3'd1;
					end
					8'hAB, 8'hAA, 8'hA8: fc = 4'd3;
					8'hEB, 8'hEA, 8'hE8: fc = 4'd4;
					8'h3B, 8'h3A, 8'h38: fc = 4'd1;
					8'hD8: begin
						fc = 4'd2;
						sz = `SIZE_WORD;
					end
					8'hD3, 8'hD2, 8'hD0: fc = 4'd1;
					8'hD4: begin
						fc = 4'd1;
						sz = `SIZE_WORD;
					end
					default: ill = 1'b1;
				endcase
			end
			// An unassigned opcode must not touch the flags or claim operands
			if (ill) begin
				fc = `FC_NONE;
				cnt = 3'd0;
			end
			res = 12'h000;
			res[`ST_CASE_LO +: 4] = fc;
			res[`ST_SIZE_LO +: 2] = sz;
			res[`ST_COUNT_LO +: 3] = cnt;
			res[`ST_ILLEGAL] = ill;
			res[`ST_READS_X] = rx;
			decode = res;
		end
	endfunction

	// Sign bit of a value at the operand size
	function msb_at;
		input [1:0] sz;
		input [31:0] val;
		begin
			if (sz == `SIZE_BYTE)
				msb_at = val[7];
			else if (sz == `SIZE_HALF)
				msb_at = val[15];
			else
				msb_at = val[31];
		end
	endfunction

	// Zero test at the operand size
	function zero_at;
		input [1:0] sz;
		input [31:0] val;
		begin
			if (sz == `SIZE_BYTE)
				zero_at = (val[7:0] == 8'h00);
			else if (sz == `SIZE_HALF)
				zero_at = (val[15:0] == 16'h0000);
			else
				zero_at = (val == 32'h0000_0000);
		end
	endfunction

	// Register map, byte offsets:
	// 0x00 control: opcode, two-byte flag and operand-mode qualifiers
	// 0x04 destination result, already truncated to 32 bits
	// 0x08 upper half of a wide result magnitude
	// 0x0C source operand
	// 0x10 raw carry/borrow (bit 0) and overflow (bit 1) from the datapath
	// 0x14 status word, direct load
	// 0x18 status word to load or restore, or a coprocessor status word
	// 0x1C decode status: case, size, count, illegal, sticky overflow, extend use
	// 0x20 execute strobe, any write
	reg [`CTRL_WIDTH-1:0] ctrl_reg;
	reg [31:0] dst_reg;
	reg [31:0] dst_hi_reg;
	reg [31:0] src_reg;
	reg [1:0] alu_reg;
	reg [31:0] loaded_reg;
	reg [11:0] status_reg;
	reg ovf_sticky_reg;
	reg exec_reg;

	wire [11:0] dec = decode(ctrl_reg[`CTRL_OPC_HI:0], ctrl_reg[`CTRL_TWO_BYTE]);
	wire [3:0] dec_case = dec[3:0];
	wire [1:0] dec_size = dec[5:4];
	wire dec_illegal = dec[`ST_ILLEGAL];

	wire apb_setup = psel & ~penable;
	wire apb_write = psel & penable & pready & pwrite;
	wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `EXEC_OFF);
	// Shared write selects for the execute process
	wire wr_psw = apb_write && (paddr == `PSW_OFF);
	wire wr_status = apb_write && (paddr == `STATUS_OFF);

	// Computed flags {N, Z, C, V} and whether the case changes them
	reg [3:0] nzcv;
	reg ovf_exc_next;
	reg [31:0] psw_next;
	reg wide_clear;

	always @* begin
		nzcv = 4'h0;
		ovf_exc_next = 1'b0;
		psw_next = processor_status_word;
		// Narrow magnitude: the full product fits 32 bits but sets bit 31
		wide_clear = (dec_size == `SIZE_WORD) && (dst_hi_reg == 32'h0000_0000) && dst_reg[31];
		case (dec_case)
			4'd1: nzcv = {msb_at(dec_size, dst_reg), zero_at(dec_size, dst_reg), 1'b0,
				ctrl_reg[`CTRL_EXPANDED] & ctrl_reg[`CTRL_TRUNC]};
			4'd2: nzcv = {msb_at(dec_size, dst_reg), zero_at(dec_size, dst_reg),
				alu_reg[`ALU_CARRY], alu_reg[`ALU_OVF]};
			4'd3: nzcv = {msb_at(dec_size, dst_reg), zero_at(dec_size, dst_reg), 1'b0,
				alu_reg[`ALU_OVF]};
			4'd4: nzcv = {msb_at(dec_size, dst_reg), zero_at(dec_size, dst_reg), 1'b0,
				alu_reg[`ALU_OVF] & ~wide_clear};
			4'd5: nzcv = {msb_at(dec_size, dst_reg), zero_at(dec_size, dst_reg), 1'b0,
				ctrl_reg[`CTRL_TYPE_CHG] & alu_reg[`ALU_OVF]};
			4'd6: nzcv = {ctrl_reg[`CTRL_SRC_SIGNED] & msb_at(dec_size, src_reg),
				zero_at(dec_size, src_reg), 2'b00};
			// Packed decimal results are judged on the whole word, not the operand size
			4'd7: nzcv = {dst_reg[31], dst_reg == 32'h0000_0000, 2'b00};
			default: nzcv = 4'h0;
		endcase
		// Arithmetic cases raise the exception on overflow; result is already truncated
		if (dec_case >= 4'd2 && dec_case <= 4'd5)
			ovf_exc_next = alu_reg[`ALU_OVF];
		if (dec_case >= 4'd1 && dec_case <= 4'd7) begin
			// A status-word source leaves the flags alone, except in case 7
			if (dec_case == 4'd7 || !ctrl_reg[`CTRL_PSW_SRC]) begin
				if (dec_case != 4'd7 && ctrl_reg[`CTRL_PSW_DST])
					psw_next[`PSW_FLAG_HI:`PSW_FLAG_LO] = dst_reg[`PSW_FLAG_HI:`PSW_FLAG_LO];
				else
					psw_next[`PSW_FLAG_HI:`PSW_FLAG_LO] = {nzcv[3], nzcv[2], nzcv[1], nzcv[0]};
			end
		end else if (dec_case == 4'd8 || dec_case == 4'd9) begin
			// Cases 8 to 10 are reserved codes; no opcode decoded here yields them
			psw_next = loaded_reg;
		end else if (dec_case == 4'd10) begin
			if (ctrl_reg[`CTRL_COP_ACCEPT])
				psw_next[`PSW_FLAG_HI:`PSW_FLAG_LO] = loaded_reg[`PSW_FLAG_HI:`PSW_FLAG_LO];
		end else if (dec_case == `FC_EXT_CLR) begin
			psw_next[`PSW_X] = 1'b0;
		end else if (dec_case == `FC_EXT_SET) begin
			psw_next[`PSW_X] = 1'b1;
		end
	end

	// APB slave: no wait states; read data still comes from a flip-flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			// Ready follows only a setup cycle, so each transfer gets one answer
			pready <= apb_setup;
			// Misaligned or unmapped addresses answer with an error rather than a hang
			pslverr <= apb_setup & ~addr_ok;
			// Read data is captured at setup so it stands through the access phase
			if (apb_setup & ~pwrite) begin
				if (paddr == `CTRL_OFF)
					prdata <= {8'h00, ctrl_reg};
				else if (paddr == `DST_OFF)
					prdata <= dst_reg;
				else if (paddr == `DST_HI_OFF)
					prdata <= dst_hi_reg;
				else if (paddr == `SRC_OFF)
					prdata <= src_reg;
				else if (paddr == `ALU_OFF)
					prdata <= {30'h0000_0000, alu_reg};
				else if (paddr == `PSW_OFF)
					prdata <= processor_status_word;
				else if (paddr == `LOADED_OFF)
					prdata <= loaded_reg;
				else if (paddr == `STATUS_OFF)
					prdata <= {20'h0_0000, status_reg[11], ovf_sticky_reg, status_reg[9:0]};
				else
					prdata <= 32'h0000_0000;
			end
		end
	end

	// Software-written registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `CTRL_RESET;
			dst_reg <= 32'h0000_0000;
			dst_hi_reg <= 32'h0000_0000;
			src_reg <= 32'h0000_0000;
			alu_reg <= 2'h0;
			loaded_reg <= 32'h0000_0000;
			exec_reg <= 1'b0;
		end else begin
			exec_reg <= 1'b0;
			if (apb_write) begin
				if (paddr == `CTRL_OFF)
					ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
				else if (paddr == `DST_OFF)
					dst_reg <= pwdata;
				else if (paddr == `DST_HI_OFF)
					dst_hi_reg <= pwdata;
				else if (paddr == `SRC_OFF)
					src_reg <= pwdata;
				else if (paddr == `ALU_OFF)
					alu_reg <= pwdata[1:0];
				else if (paddr == `LOADED_OFF)
					loaded_reg <= pwdata;
				else if (paddr == `EXEC_OFF)
					exec_reg <= 1'b1;
			end
		end
	end

	// Execute: latch decode, update the status word, pulse the event outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			processor_status_word <= `PSW_RESET;
			status_reg <= 12'h000;
			ovf_sticky_reg <= 1'b0;
			illegal_opcode <= 1'b0;
			integer_overflow <= 1'b0;
		end else begin
			illegal_opcode <= exec_reg & dec_illegal;
			integer_overflow <= exec_reg & ovf_exc_next;
			// A direct status-word load loses to an execute in the same cycle
			if (exec_reg) begin
				// Bit 10 stays clear here; the sticky overflow is kept apart
				status_reg <= dec;
				processor_status_word <= psw_next;
			end else if (wr_psw) begin
				processor_status_word <= pwdata;
			end
			// A new overflow wins over a clear in the same cycle
			if (exec_reg & ovf_exc_next)
				ovf_sticky_reg <= 1'b1;
			else if (wr_status && pwdata[`ST_OVF_EXC])
				ovf_sticky_reg <= 1'b0;
		end
	end

endmodule // opcode_decode_and_flag_logic

// File: include/opdec_defs.vh
// Constants for the opcode decoder and condition-flag unit: APB offsets,
// field positions, reset values and flag-case codes.
// Assumes a 32-bit APB with word-aligned registers.
`ifndef OPDEC_DEFS_VH
`define OPDEC_DEFS_VH

// Register byte offsets
`define CTRL_OFF 8'h00
`define DST_OFF 8'h04
`define DST_HI_OFF 8'h08
`define SRC_OFF 8'h0C
`define ALU_OFF 8'h10
`define PSW_OFF 8'h14
`define LOADED_OFF 8'h18
`define STATUS_OFF 8'h1C
`define EXEC_OFF 8'h20

// Control register fields
`define CTRL_OPC_HI 15
`define CTRL_TWO_BYTE 16
`define CTRL_EXPANDED 17
`define CTRL_TRUNC 18
`define CTRL_TYPE_CHG 19
`define CTRL_PSW_SRC 20
`define CTRL_PSW_DST 21
`define CTRL_SRC_SIGNED 22
`define CTRL_COP_ACCEPT 23
`define CTRL_WIDTH 24

// ALU flag inputs
`define ALU_CARRY 0
`define ALU_OVF 1

// Status word flag positions
`define PSW_V 18
`define PSW_C 19
`define PSW_Z 20
`define PSW_N 21
`define PSW_X 22
`define PSW_FLAG_LO 18
`define PSW_FLAG_HI 21

// Status register fields
`define ST_CASE_LO 0
`define ST_SIZE_LO 4
`define ST_COUNT_LO 6
`define ST_ILLEGAL 9
`define ST_OVF_EXC 10
`define ST_READS_X 11

// Operand sizes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Flag cases; zero means flags unchanged
`define FC_NONE 4'h0
`define FC_EXT_CLR 4'hB
`define FC_EXT_SET 4'hC

// Two-byte opcode prefix
`define PREFIX_BYTE 8'h30

`define PSW_RESET 32'h0000_0000
`define CTRL_RESET 24'h00_0000

`endif

// File: tb/opdec_asserts.sv
// Port checker for the opcode decoder: APB handshake, pulses, status word.
// Assumes a bind onto the decoder top module; it sees that module's ports only.
`timescale 1ns/1ps
`include "opdec_defs.vh"
module opdec_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [31:0] processor_status_word,
	input wire illegal_opcode,
	input wire integer_overflow
);
	wire acc = psel & penable & pready & pwrite;
	wire exec_acc = acc & (paddr == `EXEC_OFF);
	wire psw_wr = acc & (paddr == `PSW_OFF);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	ready_once_a: assert property (pready |=> !pready)
		else $error("pready held");
	bad_addr_a: assert property (psel && !penable && paddr > 8'h20 |=> pslverr)
		else $error("no error on unmapped address");
	illegal_pulse_a: assert property (illegal_opcode |-> $past(exec_acc, 2) ##1 !illegal_opcode)
		else $error("illegal pulse wrong");
	ovf_pulse_a: assert property (integer_overflow |-> $past(exec_acc, 2) ##1 !integer_overflow)
		else $error("overflow pulse wrong");
	// Flags may only move after an execute or a direct load
	psw_cause_a: assert property (!$stable(processor_status_word) |->
		$past(exec_acc, 2) || $past(psw_wr)) else $error("status word changed unasked");
	psw_bits_a: assert property (!$past(psw_wr) |-> $stable(processor_status_word[31:23])
		&& $stable(processor_status_word[17:0])) else $error("non-flag bits changed");
	exec_c: cover property (exec_acc);
	ovf_c: cover property (integer_overflow);
	err_c: cover property (pready && pslverr);
endmodule // opdec_checker

// File: tb/test_opcode_decode_and_flag_logic.sv
// Bench for the opcode decoder: loads operands over APB, executes, checks flags.
// Assumes the decoder and its checker are compiled alongside.
`timescale 1ns/1ps
`include "opdec_defs.vh"
module test_opcode_decode_and_flag_logic;
	reg pclk = 1'h0;
	reg presetn = 1'h0;
	reg psel = 1'h0;
	reg penable = 1'h0;
	reg pwrite = 1'h0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire [31:0] processor_status_word;
	wire illegal_opcode;
	wire integer_overflow;
	integer miscompares = 0;
	integer tests_run = 0;
	integer ovf_n = 0;
	integer ill_n = 0;
	integer i;
	reg [31:0] rd;
	reg [31:0] pv;
	reg [31:0] sv;
	reg perr;
	reg [19:0] ent;
	reg two;
	reg [1:0] ez;
	// Each entry: opcode in the upper 16 bits, flag case in the low nibble
	localparam [159:0] OPS_A = 160'h00871_00861_00841_00041_008B1_008F2_008C2_001F1;
	localparam [159:0] OPS_B = 160'h001C1_00092_00CF1_00C81_00AF3_00EF4_00A73_00E44;
	localparam [159:0] OPS_C = 160'h00C05_00C73_00A37_009B7_00B81_00B31_003C2_002B6;
	localparam [159:0] OPS_D = 160'h000AC_000BB_000E0_30090_30190_30350_301F0_009C2;
	localparam [639:0] OPS = {OPS_A, OPS_B, OPS_C, OPS_D};
	opcode_decode_and_flag_logic dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.processor_status_word(processor_status_word),
		.illegal_opcode(illegal_opcode),
		.integer_overflow(integer_overflow)
	);
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		if (integer_overflow === 1'h1)
			ovf_n <= ovf_n + 1;
		if (illegal_opcode === 1'h1)
			ill_n <= ill_n + 1;
	end
	task close_out;
		begin
			if (miscompares == 0 && tests_run > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("unexpected %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			psel <= 1'h1;
			penable <= 1'h0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'h1;
			n = 0;
			@(posedge pclk);
			while (pready !== 1'h1 && n < 16) begin
				n = n + 1;
				@(posedge pclk);
			end
			if (n == 16) begin
				miscompares = miscompares + 1;
				close_out;
			end
			rd = prdata;
			perr = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge pclk);
		end
	endtask
	task op(input [31:0] c, input [31:0] d, input [31:0] h, input [31:0] s, input [31:0] a);
		begin
			apb(1'h1, `CTRL_OFF, c);
			apb(1'h1, `DST_OFF, d);
			apb(1'h1, `DST_HI_OFF, h);
			apb(1'h1, `SRC_OFF, s);
			apb(1'h1, `ALU_OFF, a);
			apb(1'h1, `EXEC_OFF, 32'h0);
			apb(1'h0, `PSW_OFF, 32'h0);
			pv = rd;
			apb(1'h0, `STATUS_OFF, 32'h0);
			sv = rd;
		end
	endtask
	task fo(input [31:0] c, d, h, s, a, input [3:0] e);
		begin
			op(c, d, h, s, a);
			chk("flags", {28'h0, e}, {28'h0, pv[21:18]});
		end
	endtask
	task t_bus;
		begin
			apb(1'h0, `PSW_OFF, 32'h0);
			chk("psw", `PSW_RESET, rd);
			apb(1'h0, 8'h40, 32'h0);
			chk("pslverr", 32'h1, {31'h0, perr});
			chk("rdata", 32'h0, rd);
		end
	endtask
	task t_decode;
		begin
			for (i = 0; i < 32; i = i + 1) begin
				ent = OPS[i*20 +: 20];
				two = (ent[19:12] == `PREFIX_BYTE);
				op({15'h0, two, ent[19:4]}, 32'h1, 32'h0, 32'h0, 32'h0);
				chk("case", {28'h0, ent[3:0]}, {28'h0, sv[3:0]});
				ez = two ? `SIZE_WORD : (ent[5:4] == 2'h3) ? `SIZE_BYTE :
					(ent[5:4] == 2'h2) ? `SIZE_HALF : `SIZE_WORD;
				chk("size", {30'h0, ez}, {30'h0, sv[5:4]});
				chk("illegal", 32'h0, {31'h0, sv[9]});
			end
		end
	endtask
	task t_flags;
		begin
			fo(32'h0006_0084, 32'h0, 32'h0, 32'h0, 32'h0, 4'h5);
			fo(32'h87, 32'h100, 32'h0, 32'h0, 32'h0, 4'h4);
			fo(32'h9C, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h3, 4'hB);
			chk("sticky", 32'h1, {31'h0, sv[10]});
			fo(32'h3C, 32'h0, 32'h0, 32'h0, 32'h1, 4'h6);
			fo(32'hAC, 32'h0, 32'h0, 32'h0, 32'h3, 4'h5);
			fo(32'hEC, 32'h8000_0000, 32'h0, 32'h0, 32'h2, 4'h8);
			fo(32'hEC, 32'h8000_0000, 32'h1, 32'h0, 32'h2, 4'h9);
			fo(32'hC0, 32'h5, 32'h0, 32'h0, 32'h2, 4'h0);
			fo(32'h0008_00C0, 32'h5, 32'h0, 32'h0, 32'h2, 4'h1);
			fo(32'h0040_0028, 32'h1, 32'h0, 32'h8000_0000, 32'h0, 4'h8);
			fo(32'h28, 32'h1, 32'h0, 32'h8000_0000, 32'h0, 4'h0);
			fo(32'h28, 32'h5, 32'h0, 32'h0, 32'h0, 4'h4);
			fo(32'hA3, 32'h8000_0000, 32'h0, 32'h0, 32'h1, 4'h8);
			chk("reads_x", 32'h1, {31'h0, sv[11]});
			chk("overflow", 32'h6, ovf_n);
			fo(32'h0020_0084, 32'h0028_0000, 32'h0, 32'h0, 32'h0, 4'hA);
			fo(32'h0010_0084, 32'h0, 32'h0, 32'h0, 32'h0, 4'hA);
		end
	endtask
	task t_extend;
		begin
			op(32'h0A, 32'h0, 32'h0, 32'h0, 32'h0);
			chk("psw", 32'h0068_0000, pv);
			op(32'h0001_3009, 32'h0, 32'h0, 32'h0, 32'h0);
			chk("psw", 32'h0068_0000, pv);
			op(32'h0B, 32'h0, 32'h0, 32'h0, 32'h0);
			chk("psw", 32'h0028_0000, pv);
			chk("psw_pin", 32'h0028_0000, processor_status_word);
			op(32'h01, 32'h0, 32'h0, 32'h0, 32'h0);
			chk("illegal", 32'h1, {31'h0, sv[9]});
			chk("ill_cnt", 32'h1, ill_n);
		end
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_bus;
		t_decode;
		t_flags;
		t_extend;
		close_out;
	end
endmodule // test_opcode_decode_and_flag_logic
bind opcode_decode_and_flag_logic opdec_checker chk_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.processor_status_word(processor_status_word),
	.illegal_opcode(illegal_opcode),
	.integer_overflow(integer_overflow)
);
